/* logic/fmc_pkg.sv */
// Constants, register map and state record of the fan monitor/control block.
// Assumes a 10 MHz pclk and an APB master; converter and pins sit outside.
// Function
// [RULE1] In manual mode software watches readings and programs each drive duty itself.
// [RULE2] In automatic mode the block adjusts every drive from temperatures and fan speeds.
// [RULE3] Automatic duty uses zone temperature, low and high limits, and present fan speed.
// [RULE4] Each drive may follow any one, several or all thermal zones.
// [RULE5] Fan speed is set by duty cycle, at a high or a low output rate.
// [RULE6] With ramping on, duty moves toward its target by a bounded step per tick.
// [RULE7] Each measured fan period is compared with a limit to flag a stalled fan.
// [RULE8] An out-of-limit reading asserts the active-low open-drain interrupt pin.
// [RULE9] Monitor two remote zones, the ambient zone, processor voltage and supply.
// [RULE10] Continuous mode converts all channels back to back without pause.
// [RULE11] Cycle mode converts all channels once, then idles about one second.
// [RULE12] Entering or leaving Sleep or Shutdown leaves all registers unchanged.
// [RULE13] Sleep stops converter and monitoring; every register stays accessible.
// [RULE14] Shutdown stops the oscillator, converter and monitoring cycle.
// [RULE15] In Shutdown only the control register answers; others return an error.
// [RULE16] Third drive pin low at power-on selects address select mode.
// [RULE17] In address select mode the fourth speed input picks the slave address.
// [RULE18] In chain test mode the first drive pin carries the chain result.
// [RULE19] Strap and address pin are sampled once after reset and then held.
package fmc_pkg;

  localparam int CLK_PERIOD_NS   = 100;
  localparam int CYCLE_IDLE_MS   = 1000;
  localparam int CYCLE_IDLE_CYC  = CYCLE_IDLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RAMP_TICK_MS    = 10;
  localparam int RAMP_TICK_CYC   = RAMP_TICK_MS * 1000000 / CLK_PERIOD_NS;

  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_MASK    = 8'h08;
  localparam logic [7:0] REG_FCFG0   = 8'h10;
  localparam logic [7:0] REG_ZLIM0   = 8'h20;
  localparam logic [7:0] REG_VLIM    = 8'h2C;
  localparam logic [7:0] REG_TLIM0   = 8'h30;
  localparam logic [7:0] REG_TEMP    = 8'h40;
  localparam logic [7:0] REG_VOLT    = 8'h44;
  localparam logic [7:0] REG_DUTY    = 8'h48;
  localparam logic [7:0] REG_ADDR    = 8'h4C;
  localparam logic [7:0] REG_PERIOD0 = 8'h50;

  localparam int CTRL_START  = 0;
  localparam int CTRL_CYCLE  = 1;
  localparam int CTRL_SLEEP  = 2;
  localparam int CTRL_SHUT   = 3;
  localparam int CTRL_XOR    = 4;
  localparam int CTRL_INTPIN = 5;

  localparam int FCFG_ZONE = 0;
  localparam int FCFG_AUTO = 3;
  localparam int FCFG_HF   = 4;
  localparam int FCFG_RAMP = 5;
  localparam int FCFG_MAN  = 8;
  localparam int FCFG_MIN  = 16;
  localparam int FCFG_STEP = 24;

  localparam int ST_TEMP = 0;
  localparam int ST_VOLT = 3;
  localparam int ST_FAN  = 5;

  localparam int GAIN_SHIFT = 2;
  localparam logic [2:0]  LAST_CH     = 3'h4;
  localparam logic [2:0]  ADDR_SETTLE = 3'h5;
  localparam logic [10:0] PWM_HF_DIV  = 11'h002;
  localparam logic [10:0] PWM_LF_DIV  = 11'h400;
  localparam logic [15:0] TACH_SAT    = 16'hFFFF;
  localparam logic [7:0]  DUTY_FULL   = 8'hFF;

  typedef enum logic [1:0] {
    MON_OFF  = 2'b00,
    MON_REQ  = 2'b01,
    MON_WAIT = 2'b10,
    MON_IDLE = 2'b11
  } fmc_mon_t;

  typedef struct packed {
    logic [5:0]        ctrl;
    logic [8:0]        st;
    logic [8:0]        mask;
    logic [2:0][31:0]  fcfg;
    logic [2:0][15:0]  zlim;
    logic [31:0]       vlim;
    logic [3:0][15:0]  tlim;
    logic [2:0][7:0]   temp;
    logic [1:0][7:0]   volt;
    logic [2:0][7:0]   duty;
    logic [3:0][15:0]  period;
    logic [3:0][15:0]  tcnt;
    logic [3:0][2:0]   tsync;
    logic [3:0]        tlvl;
    logic [2:0]        ssync;
    logic              slvl;
    logic [3:0]        slow;
    fmc_mon_t          mon;
    logic [2:0]        ch;
    logic [23:0]       idle;
    logic              adc_start;
    logic [2:0][10:0]  pre;
    logic [2:0][7:0]   pcnt;
    logic [19:0]       rcnt;
    logic              chain;
    logic [6:0]        addr;
    logic              amode;
    logic              adone;
    logic [2:0]        acnt;
    logic [31:0]       prdata;
  } fmc_state_t;

endpackage

/* logic/fmc_top.sv */
// Fan monitor/control core: APB registers, monitor sequencer, fan speed
// timing, three duty-cycle drives, interrupt and power-on strap capture.
// Assumes the converter answers adc_done on pclk; pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module fmc_top
#(
  parameter int unsigned IDLE_CYCLES = fmc_pkg::CYCLE_IDLE_CYC,
  parameter int unsigned RAMP_CYCLES = fmc_pkg::RAMP_TICK_CYC,
  parameter logic [6:0]  ADDR_DEF    = 7'h2E,
  parameter logic [6:0]  ADDR_LO     = 7'h2C,
  parameter logic [6:0]  ADDR_HI     = 7'h2D
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             adc_start,
  output logic      [2:0]  adc_channel,
  input  wire logic        adc_done,
  input  wire logic [7:0]  adc_data,
  input  wire logic        fan_speed_in_1,
  input  wire logic        fan_speed_in_2,
  input  wire logic        fan_speed_in_3,
  input  wire logic        fan_speed_in_4,
  output logic             fan_drive_out_1,
  output logic             fan_drive_out_2_o,
  output logic             fan_drive_out_2_oe_n,
  input  wire logic        fan_drive_out_3_i,
  output logic             fan_drive_out_3_o,
  output logic             fan_drive_out_3_oe_n,
  output logic             irq,
  output logic             osc_enable,
  output logic      [6:0]  smbus_addr,
  output logic             addr_select_mode
);

  fmc_pkg::fmc_state_t s_r;
  fmc_pkg::fmc_state_t s_nxt;
  logic [3:0]          tach_pin;
  logic [2:0]          pwm_w;
  logic                shut;
  logic                run;
  logic                acc;
  logic                ok;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int idx);
    hit = (a == 8'(base + 8'(4 * idx)));
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = 1'b0;
    if (a == fmc_pkg::REG_CTRL || a == fmc_pkg::REG_STATUS || a == fmc_pkg::REG_MASK ||
        a == fmc_pkg::REG_VLIM || a == fmc_pkg::REG_TEMP || a == fmc_pkg::REG_VOLT ||
        a == fmc_pkg::REG_DUTY || a == fmc_pkg::REG_ADDR)
      mapped = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (hit(a, fmc_pkg::REG_TLIM0, i) || hit(a, fmc_pkg::REG_PERIOD0, i))
        mapped = 1'b1;
      if (i < 3 && (hit(a, fmc_pkg::REG_FCFG0, i) || hit(a, fmc_pkg::REG_ZLIM0, i)))
        mapped = 1'b1;
    end
  endfunction

  function automatic logic [7:0] auto_duty(input logic [7:0] t, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic [7:0] mn);
    logic [10:0] sum;
    sum = 11'h000;
    if (t >= hi)
      return fmc_pkg::DUTY_FULL;
    if (t < lo)
      return 8'h00;
    sum = {3'h0, mn} + ({3'h0, 8'(t - lo)} << fmc_pkg::GAIN_SHIFT);
    return (sum > 11'h0FF) ? fmc_pkg::DUTY_FULL : sum[7:0];
  endfunction

  function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
    absdiff = (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction

  assign tach_pin = {fan_speed_in_4, fan_speed_in_3, fan_speed_in_2, fan_speed_in_1};
  assign shut     = s_r.ctrl[fmc_pkg::CTRL_SHUT];
  assign run      = s_r.ctrl[fmc_pkg::CTRL_START] & ~s_r.ctrl[fmc_pkg::CTRL_SLEEP] & ~shut;
  assign acc      = psel & penable;
  // Shutdown leaves only the control word reachable
  assign ok       = mapped(paddr) & (~shut | paddr == fmc_pkg::REG_CTRL); // RULE15

  always_comb
  begin
    logic [8:0] ev;
    logic [7:0] tgt;
    logic [7:0] step;
    logic       rtick;
    logic       rise;
    logic       wr;
    ev    = 9'h000;
    tgt   = 8'h00;
    step  = 8'h00;
    rtick = 1'b0;
    rise  = 1'b0;
    wr    = acc & pwrite & ok;
    s_nxt = s_r;
    s_nxt.adc_start = 1'b0;

    // Pin synchronisers: a level counts once stages two and three agree
    for (int f = 0; f < 4; f++)
    begin
      s_nxt.tsync[f] = {s_r.tsync[f][1:0], tach_pin[f]};
      if (s_r.tsync[f][1] == s_r.tsync[f][2])
        s_nxt.tlvl[f] = s_r.tsync[f][1];
    end
    s_nxt.ssync = {s_r.ssync[1:0], fan_drive_out_3_i};
    if (s_r.ssync[1] == s_r.ssync[2])
      s_nxt.slvl = s_r.ssync[1];
    s_nxt.chain = ^{s_r.tlvl, s_r.slvl}; // RULE18

    // One capture after reset; the strap pin is released until then
    if (!s_r.adone)
    begin
      s_nxt.acnt = 3'(s_r.acnt + 3'h1);
      if (s_r.acnt == fmc_pkg::ADDR_SETTLE)
      begin
        s_nxt.adone = 1'b1; // RULE19
        s_nxt.amode = ~s_r.slvl; // RULE16
        s_nxt.addr  = ~s_r.slvl ? (s_r.tlvl[3] ? ADDR_HI : ADDR_LO) : ADDR_DEF; // RULE17
      end
    end

    // Monitoring sequencer
    case (s_r.mon)
      fmc_pkg::MON_OFF:
      begin
        s_nxt.ch = 3'h0;
        if (run)
          s_nxt.mon = fmc_pkg::MON_REQ;
      end
      fmc_pkg::MON_REQ:
      begin
        s_nxt.adc_start = run; // RULE13 RULE14
        s_nxt.mon = run ? fmc_pkg::MON_WAIT : fmc_pkg::MON_OFF;
      end
      fmc_pkg::MON_WAIT:
      begin
        if (adc_done)
        begin
          if (s_r.ch < 3'h3)
          begin
            s_nxt.temp[s_r.ch[1:0]] = adc_data; // RULE9
            ev[fmc_pkg::ST_TEMP + int'(s_r.ch)] = (adc_data < s_r.zlim[s_r.ch[1:0]][7:0]) |
                                                 (adc_data > s_r.zlim[s_r.ch[1:0]][15:8]);
          end
          else
          begin
            s_nxt.volt[s_r.ch[0] ? 0 : 1] = adc_data; // RULE9
            ev[fmc_pkg::ST_VOLT + (s_r.ch[0] ? 0 : 1)] = s_r.ch[0] ?
              (adc_data < s_r.vlim[7:0] | adc_data > s_r.vlim[15:8]) :
              (adc_data < s_r.vlim[23:16] | adc_data > s_r.vlim[31:24]);
          end
          if (s_r.ch == fmc_pkg::LAST_CH)
          begin
            s_nxt.ch   = 3'h0;
            s_nxt.idle = 24'h000000;
            s_nxt.mon  = s_r.ctrl[fmc_pkg::CTRL_CYCLE] ? fmc_pkg::MON_IDLE // RULE11
                                                      : fmc_pkg::MON_REQ; // RULE10
          end
          else
          begin
            s_nxt.ch  = 3'(s_r.ch + 3'h1);
            s_nxt.mon = fmc_pkg::MON_REQ;
          end
          if (!run)
            s_nxt.mon = fmc_pkg::MON_OFF;
        end
      end
      fmc_pkg::MON_IDLE:
      begin
        s_nxt.idle = 24'(s_r.idle + 24'h000001);
        if (s_r.idle == 24'(IDLE_CYCLES - 1))
          s_nxt.mon = fmc_pkg::MON_REQ; // RULE11
        if (!run)
          s_nxt.mon = fmc_pkg::MON_OFF;
      end
      default:
        s_nxt.mon = fmc_pkg::MON_OFF;
    endcase

    // Fan period timing, frozen while the oscillator is stopped
    for (int f = 0; f < 4; f++)
    begin
      rise = (s_r.tsync[f][1] == s_r.tsync[f][2]) & s_r.tsync[f][1] & ~s_r.tlvl[f];
      if (!shut)
      begin
        if (rise)
        begin
          s_nxt.period[f] = s_r.tcnt[f];
          s_nxt.tcnt[f]   = 16'h0000;
          s_nxt.slow[f]   = s_r.tcnt[f] > s_r.tlim[f]; // RULE7
          ev[fmc_pkg::ST_FAN + f] = s_r.tcnt[f] > s_r.tlim[f]; // RULE7
        end
        else if (s_r.tcnt[f] != fmc_pkg::TACH_SAT)
        begin
          s_nxt.tcnt[f] = 16'(s_r.tcnt[f] + 16'h0001);
          // A seized fan gives no edge at all; flag it on saturation
          if (s_r.tcnt[f] == 16'(fmc_pkg::TACH_SAT - 16'h0001))
          begin
            s_nxt.slow[f]   = 1'b1;
            ev[fmc_pkg::ST_FAN + f] = 1'b1; // RULE7
          end
        end
      end
    end

    // Drives
    if (!shut)
    begin
      rtick = (s_r.rcnt == 20'(RAMP_CYCLES - 1));
      s_nxt.rcnt = rtick ? 20'h00000 : 20'(s_r.rcnt + 20'h00001);
    end
    for (int d = 0; d < 3; d++)
    begin
      step = s_r.fcfg[d][fmc_pkg::FCFG_STEP +: 8];
      if (s_r.fcfg[d][fmc_pkg::FCFG_AUTO])
      begin
        tgt = 8'h00;
        for (int z = 0; z < 3; z++)
          if (s_r.fcfg[d][fmc_pkg::FCFG_ZONE + z]) // RULE4
            if (auto_duty(s_r.temp[z], s_r.zlim[z][7:0], s_r.zlim[z][15:8],
                          s_r.fcfg[d][fmc_pkg::FCFG_MIN +: 8]) > tgt)
              tgt = auto_duty(s_r.temp[z], s_r.zlim[z][7:0], s_r.zlim[z][15:8],
                              s_r.fcfg[d][fmc_pkg::FCFG_MIN +: 8]); // RULE2 RULE3
        if (s_r.slow[d])
          tgt = fmc_pkg::DUTY_FULL; // RULE3
      end
      else
        tgt = s_r.fcfg[d][fmc_pkg::FCFG_MAN +: 8]; // RULE1
      if (!shut)
      begin
        if (!s_r.fcfg[d][fmc_pkg::FCFG_RAMP])
          s_nxt.duty[d] = tgt;
        else if (rtick)
          s_nxt.duty[d] = (absdiff(tgt, s_r.duty[d]) <= step) ? tgt :
                          (tgt > s_r.duty[d]) ? 8'(s_r.duty[d] + step)
                                              : 8'(s_r.duty[d] - step); // RULE6
        if (s_r.pre[d] >= 11'((s_r.fcfg[d][fmc_pkg::FCFG_HF] ? fmc_pkg::PWM_HF_DIV
                                                             : fmc_pkg::PWM_LF_DIV) - 11'h001))
        begin
          s_nxt.pre[d]  = 11'h000; // RULE5
          s_nxt.pcnt[d] = 8'(s_r.pcnt[d] + 8'h01);
        end
        else
          s_nxt.pre[d] = 11'(s_r.pre[d] + 11'h001);
      end
    end

    // Register writes; low-power bits touch no other register
    if (wr)
    begin
      if (paddr == fmc_pkg::REG_CTRL)
        s_nxt.ctrl = pwdata[5:0]; // RULE12
      if (paddr == fmc_pkg::REG_MASK)
        s_nxt.mask = pwdata[8:0];
      if (paddr == fmc_pkg::REG_VLIM)
        s_nxt.vlim = pwdata;
      for (int i = 0; i < 4; i++)
      begin
        if (hit(paddr, fmc_pkg::REG_TLIM0, i))
          s_nxt.tlim[i] = pwdata[15:0];
        if (i < 3 && hit(paddr, fmc_pkg::REG_FCFG0, i))
          s_nxt.fcfg[i] = pwdata;
        if (i < 3 && hit(paddr, fmc_pkg::REG_ZLIM0, i))
          s_nxt.zlim[i] = pwdata[15:0];
      end
    end
    // New events win over a same-cycle clear
    s_nxt.st = (s_r.st & ~((wr && paddr == fmc_pkg::REG_STATUS) ? pwdata[8:0] : 9'h000)) | ev;

    // Read data is loaded in the setup phase
    if (psel && !penable)
    begin
      s_nxt.prdata = 32'h00000000;
      if (ok)
      begin
        case (paddr)
          fmc_pkg::REG_CTRL:   s_nxt.prdata = {26'h0000000, s_r.ctrl};
          fmc_pkg::REG_STATUS: s_nxt.prdata = {23'h000000, s_r.st};
          fmc_pkg::REG_MASK:   s_nxt.prdata = {23'h000000, s_r.mask};
          fmc_pkg::REG_VLIM:   s_nxt.prdata = s_r.vlim;
          fmc_pkg::REG_TEMP:   s_nxt.prdata = {8'h00, s_r.temp};
          fmc_pkg::REG_VOLT:   s_nxt.prdata = {16'h0000, s_r.volt};
          fmc_pkg::REG_DUTY:   s_nxt.prdata = {8'h00, s_r.duty};
          fmc_pkg::REG_ADDR:   s_nxt.prdata = {23'h000000, s_r.amode, 1'b0, s_r.addr};
          default:
          begin
            for (int i = 0; i < 4; i++)
            begin
              if (hit(paddr, fmc_pkg::REG_TLIM0, i))
                s_nxt.prdata = {16'h0000, s_r.tlim[i]};
              if (hit(paddr, fmc_pkg::REG_PERIOD0, i))
                s_nxt.prdata = {16'h0000, s_r.period[i]};
              if (i < 3 && hit(paddr, fmc_pkg::REG_FCFG0, i))
                s_nxt.prdata = s_r.fcfg[i];
              if (i < 3 && hit(paddr, fmc_pkg::REG_ZLIM0, i))
                s_nxt.prdata = {16'h0000, s_r.zlim[i]};
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r       <= '0;
      s_r.slvl  <= 1'b1;
      s_r.ssync <= 3'h7;
    end
    else if (clk_en)
      s_r <= s_nxt;
  end

  always_comb
  begin
    for (int d = 0; d < 3; d++)
      pwm_w[d] = (s_r.duty[d] == fmc_pkg::DUTY_FULL) | (s_r.pcnt[d] < s_r.duty[d]); // RULE5
  end

  assign prdata               = s_r.prdata;
  assign pready               = 1'b1;
  assign pslverr              = acc & ~ok; // RULE15
  assign adc_start            = s_r.adc_start;
  assign adc_channel          = s_r.ch;
  assign irq                  = |(s_r.st & s_r.mask); // RULE8
  assign fan_drive_out_1      = s_r.ctrl[fmc_pkg::CTRL_XOR] ? s_r.chain : pwm_w[0]; // RULE18
  assign fan_drive_out_2_o    = 1'b0;
  assign fan_drive_out_2_oe_n = s_r.ctrl[fmc_pkg::CTRL_INTPIN] ? ~irq : pwm_w[1]; // RULE8
  assign fan_drive_out_3_o    = 1'b0;
  assign fan_drive_out_3_oe_n = ~s_r.adone | pwm_w[2]; // RULE16
  assign osc_enable           = ~shut; // RULE14
  assign smbus_addr           = s_r.addr;
  assign addr_select_mode     = s_r.amode;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_IRQ_LEVEL: assert property (irq == |(s_r.st & s_r.mask)) // RULE8
    else $error("irq does not follow masked status");
  AST_INT_PIN: assert property (s_r.ctrl[fmc_pkg::CTRL_INTPIN] && irq |->
                                !fan_drive_out_2_oe_n && !fan_drive_out_2_o) // RULE8
    else $error("interrupt pin not pulled low");
  AST_SLEEP_IDLE: assert property (clk_en && s_r.ctrl[fmc_pkg::CTRL_SLEEP] |=> !adc_start) // RULE13
    else $error("conversion started in sleep");
  AST_SHUT_IDLE: assert property (clk_en && shut |-> !osc_enable ##1 !adc_start) // RULE14
    else $error("activity in shutdown");
  AST_SHUT_REFUSE: assert property (acc && shut && paddr != fmc_pkg::REG_CTRL |-> pslverr) // RULE15
    else $error("access allowed in shutdown");
  AST_ADDR_HOLD: assert property (s_r.adone && $past(s_r.adone) |-> $stable(smbus_addr)) // RULE19
    else $error("slave address changed");
  AST_CHAIN_OUT: assert property (s_r.ctrl[fmc_pkg::CTRL_XOR] |->
                                  fan_drive_out_1 == s_r.chain) // RULE18
    else $error("chain result missing on drive 1");
  AST_RAMP_STEP: assert property (clk_en && s_r.fcfg[0][fmc_pkg::FCFG_RAMP] |=>
      absdiff(s_r.duty[0], $past(s_r.duty[0])) <= $past(s_r.fcfg[0][fmc_pkg::FCFG_STEP +: 8]))
    else $error("duty stepped too far"); // RULE6
  AST_FULL_DUTY: assert property (!s_r.ctrl[fmc_pkg::CTRL_XOR] &&
                                  s_r.duty[0] == fmc_pkg::DUTY_FULL |-> fan_drive_out_1) // RULE5
    else $error("full duty not high");
  AST_BACK2BACK: assert property (clk_en && run && !s_r.ctrl[fmc_pkg::CTRL_CYCLE] &&
      s_r.mon == fmc_pkg::MON_WAIT && adc_done |=> s_r.mon == fmc_pkg::MON_REQ) // RULE10
    else $error("pause between conversions");
  AST_STALL_FLAG: assert property (clk_en && !shut && s_r.tcnt[1] ==
      16'(fmc_pkg::TACH_SAT - 16'h0001) && !s_nxt.tlvl[1] |=> s_r.st[fmc_pkg::ST_FAN + 1]) // RULE7
    else $error("stall not flagged");

  COV_IRQ: cover property (!irq ##1 irq);
  COV_CYCLE_IDLE: cover property (s_r.mon == fmc_pkg::MON_IDLE ##1 s_r.mon == fmc_pkg::MON_REQ);
  COV_AUTO_FULL: cover property (s_r.fcfg[0][fmc_pkg::FCFG_AUTO] &&
                                 s_r.duty[0] == fmc_pkg::DUTY_FULL);
  COV_ADDR_MODE: cover property (s_r.adone && s_r.amode);

endmodule
`default_nettype wire

/* verification/fmc_adc_model.sv */
// Converter stand-in: answers each start pulse with a result for the channel.
// Assumes one request in flight at a time, all on pclk.
`timescale 1ns/10ps
`default_nettype none
module fmc_adc_model
#(
  parameter int LAT = 3
)
(
  input  wire logic       pclk,
  input  wire logic       adc_start,
  input  wire logic [2:0] adc_channel,
  output logic            adc_done,
  output logic      [7:0] adc_data
);
  initial
  begin
    adc_done = 1'b0;
    adc_data = 8'hA5;
    forever
    begin
      @(posedge pclk);
      if (adc_start === 1'b1)
      begin
        repeat (LAT) @(posedge pclk);
        adc_done <= 1'b1;
        adc_data <= 8'h50 + {adc_channel, 4'h0};
        @(posedge pclk);
        adc_done <= 1'b0;
        // Stale result inverted so nobody reads it by luck
        adc_data <= ~adc_data;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Bench for the fan monitor core: APB scenarios with a converter model.
// Assumes fmc_top as declared; fan pins toggle at the link rate, the fourth held high until t_strap enables it.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        adc_start;
  logic [2:0]  adc_channel;
  logic        adc_done;
  logic [7:0]  adc_data;
  logic        tach;
  logic        fan_speed_in_4_on;
  logic        strap_n;
  wire logic   pin3;
  logic        drv1;
  logic        oe2_n;
  logic        oe3_n;
  logic        irq;
  logic        osc_en;
  logic [6:0]  saddr;
  logic        amode;
  logic [31:0] rd;
  logic        err;
  int          k;
  int          g;
  int          failures;
  int          comparisons;

  // Strap pulls low; otherwise a pull-up unless the block sinks
  assign pin3 = strap_n & oe3_n;

  fmc_top #(.IDLE_CYCLES(20), .RAMP_CYCLES(4)) i_fmc_top (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_done(adc_done), .adc_data(adc_data), .fan_speed_in_1(tach),
    .fan_speed_in_2(tach), .fan_speed_in_3(tach), .fan_speed_in_4(tach | ~fan_speed_in_4_on),
    .fan_drive_out_1(drv1), .fan_drive_out_2_o(), .fan_drive_out_2_oe_n(oe2_n),
    .fan_drive_out_3_i(pin3), .fan_drive_out_3_o(), .fan_drive_out_3_oe_n(oe3_n),
    .irq(irq), .osc_enable(osc_en), .smbus_addr(saddr), .addr_select_mode(amode));

  fmc_adc_model #(.LAT(3)) i_fmc_adc_model (.pclk(pclk), .adc_start(adc_start),
    .adc_channel(adc_channel), .adc_done(adc_done), .adc_data(adc_data));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Link clock, 800 ns, eight pclk periods, edges 13 ns before a rising pclk edge
  initial
  begin
    tach = 1'b0;
    #137;
    forever #400 tach = ~tach;
  end

  task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
    comparisons++;
    if (gv !== ev)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, gv, ev);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Counts start pulses and the widest gap between two of them
  task automatic starts(input int cyc);
    int c;
    k = 0;
    g = 0;
    c = 0;
    repeat (cyc)
    begin
      @(posedge pclk);
      c++;
      if (adc_start === 1'b1)
      begin
        if (k > 0 && c > g)
          g = c;
        k++;
        c = 0;
      end
    end
  endtask

  task automatic high(input int cyc);
    k = 0;
    repeat (cyc)
    begin
      @(posedge pclk);
      if (drv1 === 1'b1)
        k++;
    end
  endtask

  task automatic t_strap();
    chk(oe3_n, 1'b1);
    wait_cyc(10);
    chk(oe3_n, 1'b0);
    chk(amode, 1'b1);
    chk(saddr, 7'h2D);
    strap_n <= 1'b1;
    fan_speed_in_4_on <= 1'b1;
    wait_cyc(30);
    chk(saddr, 7'h2D);
    rdc(fmc_pkg::REG_ADDR, 32'h12D);
    bus(1'b0, 8'hFC, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask

  task automatic t_mon();
    for (int i = 0; i < 4; i++)
      wr(fmc_pkg::REG_TLIM0 + 8'(4 * i), 32'hFFFF);
    wr(fmc_pkg::REG_CTRL, 32'h1);
    wait_cyc(60);
    rdc(fmc_pkg::REG_TEMP, 32'h706050);
    rdc(fmc_pkg::REG_VOLT, 32'h9080);
    starts(70);
    chk(32'(k >= 9 && g <= 8), 32'h1);
    wr(fmc_pkg::REG_CTRL, 32'h3);
    starts(200);
    chk(32'(g > 20 && g < 35), 32'h1);
  endtask

  task automatic t_low();
    wr(fmc_pkg::REG_CTRL, 32'h5);
    wait_cyc(40);
    starts(100);
    chk(k, 0);
    chk(osc_en, 1'b1);
    rdc(fmc_pkg::REG_TEMP, 32'h706050);
    wr(fmc_pkg::REG_CTRL, 32'h9);
    wait_cyc(20);
    chk(osc_en, 1'b0);
    starts(100);
    chk(k, 0);
    bus(1'b0, fmc_pkg::REG_TEMP, 32'h0);
    chk(err, 1'b1);
    rdc(fmc_pkg::REG_CTRL, 32'h9);
    wr(fmc_pkg::REG_CTRL, 32'h1);
    rdc(fmc_pkg::REG_TEMP, 32'h706050);
  endtask

  task automatic t_irq();
    wr(fmc_pkg::REG_CTRL, 32'h21);
    wr(fmc_pkg::REG_VLIM, 32'hFF000070);
    // Drop flags left by earlier readings so only new readings can set one
    wr(fmc_pkg::REG_STATUS, 32'h1FF);
    wr(fmc_pkg::REG_MASK, 32'h8);
    wait_cyc(60);
    chk(irq, 1'b1);
    chk(oe2_n, 1'b0);
    wr(fmc_pkg::REG_MASK, 32'h0);
    wait_cyc(2);
    chk(irq, 1'b0);
    wr(fmc_pkg::REG_VLIM, 32'hFF00FF00);
    wr(fmc_pkg::REG_STATUS, 32'h8);
    wait_cyc(60);
    bus(1'b0, fmc_pkg::REG_STATUS, 32'h0);
    chk(rd[3], 1'b0);
  endtask

  task automatic t_fan();
    // Drive 3 at full duty releases its pin, the only odd input of the chain
    wr(fmc_pkg::REG_FCFG0 + 8'h08, 32'hFF00);
    wr(fmc_pkg::REG_CTRL, 32'h11);
    wait_cyc(8);
    high(16);
    chk(k, 16);
    wr(fmc_pkg::REG_FCFG0 + 8'h08, 32'h0);
    wait_cyc(8);
    high(16);
    chk(k, 0);
    wr(fmc_pkg::REG_CTRL, 32'h1);
    wr(fmc_pkg::REG_FCFG0, 32'h8010);
    wait_cyc(20);
    rdc(fmc_pkg::REG_DUTY, 32'h80);
    high(512);
    chk(k, 256);
    wr(fmc_pkg::REG_FCFG0, 32'h8000);
    high(512);
    chk(32'(k == 0 || k == 512), 32'h1);
    for (int i = 0; i < 3; i++)
      wr(fmc_pkg::REG_ZLIM0 + 8'(4 * i), 32'h8040);
    wr(fmc_pkg::REG_FCFG0, 32'h19);
    wait_cyc(60);
    rdc(fmc_pkg::REG_DUTY, 32'h40);
    wr(fmc_pkg::REG_FCFG0, 32'h1E);
    wait_cyc(60);
    rdc(fmc_pkg::REG_DUTY, 32'hC0);
    wr(fmc_pkg::REG_FCFG0, 32'h01001030);
    wait_cyc(40);
    bus(1'b0, fmc_pkg::REG_DUTY, 32'h0);
    chk(32'(rd[7:0] > 8'hB0 && rd[7:0] < 8'hC0), 32'h1);
    wr(fmc_pkg::REG_TLIM0, 32'h4);
    wait_cyc(40);
    rdc(fmc_pkg::REG_PERIOD0, 32'h7);
    bus(1'b0, fmc_pkg::REG_STATUS, 32'h0);
    chk(rd[5], 1'b1);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #3000000;
    failures++;
    print_verdict();
  end

  initial
  begin
    failures = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap_n = 1'b0;
    fan_speed_in_4_on = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_strap();
    t_mon();
    t_low();
    t_irq();
    t_fan();
    print_verdict();
  end
endmodule
`default_nettype wire
